// file: rtl/rcr_params.svh
// reset cause recorder: bit positions, reset values and vectors
// assumes a word-addressed program counter of at least three bits
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// power control register bit positions
`define RCR_OVF_BIT   7
`define RCR_UNF_BIT   6
`define RCR_GAP_BIT   5
`define RCR_WDT_BIT   4
`define RCR_PIN_BIT   3
`define RCR_INS_BIT   2
`define RCR_POR_BIT   1
`define RCR_BOR_BIT   0

// implemented bits of the power control register
`define RCR_IMPL_MASK 8'hdf
// value after power-on; brown-out bit is unknown and taken as zero
`define RCR_POR_VALUE 8'h1c

// program counter targets
`define RCR_RESET_VEC 16'h0000
`define RCR_INT_VEC   16'h0004
`define RCR_PC_STEP   16'h0001

`endif

// file: rtl/rcr_pkg.sv
// reset cause recorder: shared types
// assumes rcr_params.svh holds every numeric constant
package rcr_pkg;

   // event taken in one cycle, highest priority first
   typedef enum logic [3:0] {
      EV_NONE,
      EV_BOR,
      EV_PIN,
      EV_OVF,
      EV_UNF,
      EV_WDT,
      EV_INS,
      EV_WAKE,
      EV_SLEEP,
      EV_CLRWDT
   } rcr_ev_t;

   // core run state as seen by the recorder
   typedef enum logic [1:0] {
      ST_RUN,
      ST_SLEEP,
      ST_VEC_WAIT
   } rcr_st_t;

endpackage : rcr_pkg

// file: rtl/rcr_pin_sync.sv
// reset pin synchroniser with assertion edge detect
// assumes the pin is active low and asynchronous to clk
`timescale 1ns/10ps
module rcr_pin_sync (
   input  wire logic clk,        // core clock
   input  wire logic nrst,       // async reset, active low
   input  wire logic pin_n,      // raw pin, active low
   output logic      assert_pls  // one cycle when pin goes low
);

   logic meta;   // first stage, read only by stage two
   logic sync;   // second stage
   logic prev;   // delayed copy for edge detect

   // two-flop synchroniser; idle level is high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         prev <= 1'b1;
      end else begin
         meta <= pin_n;
         sync <= meta;
         prev <= sync;
      end
   end

   // high to low of the synchronised pin
   assign assert_pls = prev & ~sync;

endmodule : rcr_pin_sync

// file: rtl/rcr_top.sv
// reset cause recorder: cause flags, sleep state and restart address
// assumes event inputs are one-cycle pulses on clk except the pin
// Function
// (RULE_01) every reset updates flags, restarts at zero
// (RULE_02) power-on sets defaults, timeout and powerdown high
// (RULE_03) pin reset running clears only pin flag
// (RULE_04) pin reset asleep also sets timeout, clears powerdown
// (RULE_05) watchdog in sleep wakes, clears timeout, powerdown
// (RULE_06) interrupt wake sets timeout, clears powerdown
// (RULE_07) enabled interrupt wake runs next, then vectors
// (RULE_08) enabled overflow resets and sets overflow flag
// (RULE_09) enabled underflow resets and sets underflow flag
// (RULE_10) unimplemented bits always read zero
// (RULE_11) software rewrites power-on and brown-out flags
// (RULE_12) watchdog reset running clears watchdog, timeout
// (RULE_13) brown-out and reset instruction flag updates
`timescale 1ns/10ps
`include "rcr_params.svh"
module rcr_top #(
   parameter int PC_W = 15                       // program counter width
) (
   input  wire logic            clk,             // core clock, 200 MHz
   input  wire logic            nrst,            // power-on reset, active low
   input  wire logic            ext_reset_pin_n, // reset pin, active low
   input  wire logic            bor_event,       // brown-out detected
   input  wire logic            wdt_expire,      // watchdog_timer expired
   input  wire logic            reset_instr,     // reset instruction run
   input  wire logic            stack_ovf,       // stack overflow seen
   input  wire logic            stack_unf,       // stack underflow seen
   input  wire logic            int_wake,        // interrupt wants wake-up
   input  wire logic            sleep_enter,     // sleep instruction run
   input  wire logic            clrwdt_instr,    // watchdog clear instruction
   input  wire logic            stack_fault_reset_enable, // stack reset on
   input  wire logic            global_int_enable, // interrupts enabled
   input  wire logic            instr_retired,   // core finished an instruction
   input  wire logic [PC_W-1:0] core_pc,         // current core pc
   input  wire logic            power_control_reg_wr,         // software write strobe
   input  wire logic [7:0]      power_control_reg_wdata,      // software write data
   output logic      [7:0]      power_control_reg, // cause flags
   output logic                 timeout_flag,    // status time-out flag
   output logic                 powerdown_flag,  // status power-down flag
   output logic                 asleep,          // core is sleeping
   output logic                 core_restart,    // pulse: true reset
   output logic                 pc_load,         // pulse: load pc
   output logic      [PC_W-1:0] pc_load_addr,    // pc to load
   output logic                 stack_push,      // pulse: push return
   output logic      [PC_W-1:0] push_addr        // return address pushed
);

   // pc one step on from the given address
   function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] pc);
      pc_next = pc + PC_W'(`RCR_PC_STEP);
   endfunction : pc_next

   logic            pin_pls;   // synchronised pin assertion
   rcr_pkg::rcr_ev_t ev;       // event taken this cycle
   rcr_pkg::rcr_st_t st;       // run state
   logic [7:0]      next_power_control_reg; // next cause flags
   logic            sleeping;  // core in sleep this cycle
   logic            true_rst;  // event restarts the core

   rcr_pin_sync u_pin (
      .clk        (clk),
      .nrst       (nrst),
      .pin_n      (ext_reset_pin_n),
      .assert_pls (pin_pls)
   );

   assign sleeping = (st == rcr_pkg::ST_SLEEP);
   assign asleep   = sleeping;

   // pick one event by priority; stack faults only when enabled
   always_comb begin
      ev = rcr_pkg::EV_NONE;
      if (bor_event)
         ev = rcr_pkg::EV_BOR;
      else if (pin_pls)
         ev = rcr_pkg::EV_PIN;
      else if (stack_ovf && stack_fault_reset_enable)        // RULE_08
         ev = rcr_pkg::EV_OVF;
      else if (stack_unf && stack_fault_reset_enable)        // RULE_09
         ev = rcr_pkg::EV_UNF;
      else if (wdt_expire)
         ev = rcr_pkg::EV_WDT;
      else if (reset_instr && !sleeping)
         ev = rcr_pkg::EV_INS;
      else if (int_wake && sleeping)
         ev = rcr_pkg::EV_WAKE;
      else if (sleep_enter && !sleeping)
         ev = rcr_pkg::EV_SLEEP;
      else if (clrwdt_instr && !sleeping)
         ev = rcr_pkg::EV_CLRWDT;
   end

   // watchdog in sleep wakes instead of resetting
   assign true_rst = (ev == rcr_pkg::EV_BOR) || (ev == rcr_pkg::EV_PIN)
                  || (ev == rcr_pkg::EV_OVF) || (ev == rcr_pkg::EV_UNF)
                  || (ev == rcr_pkg::EV_INS)
                  || (ev == rcr_pkg::EV_WDT && !sleeping);

   // cause flags: software write first, hardware event on top so the event wins
   always_comb begin
      next_power_control_reg = power_control_reg_wr ? (power_control_reg_wdata & `RCR_IMPL_MASK)    // RULE_11
                          : power_control_reg;
      unique case (ev)
         rcr_pkg::EV_BOR: begin                              // RULE_13
            next_power_control_reg[`RCR_BOR_BIT] = 1'b0;
            next_power_control_reg[`RCR_OVF_BIT] = 1'b0;
            next_power_control_reg[`RCR_UNF_BIT] = 1'b0;
         end
         rcr_pkg::EV_PIN: next_power_control_reg[`RCR_PIN_BIT] = 1'b0;     // RULE_03
         rcr_pkg::EV_OVF: next_power_control_reg[`RCR_OVF_BIT] = 1'b1;     // RULE_08
         rcr_pkg::EV_UNF: next_power_control_reg[`RCR_UNF_BIT] = 1'b1;     // RULE_09
         rcr_pkg::EV_WDT: begin
            if (!sleeping)
               next_power_control_reg[`RCR_WDT_BIT] = 1'b0;               // RULE_12
         end
         rcr_pkg::EV_INS: next_power_control_reg[`RCR_INS_BIT] = 1'b0;     // RULE_13
         default: ;                                          // wakes keep flags
      endcase
      next_power_control_reg[`RCR_GAP_BIT] = 1'b0;                        // RULE_10
   end

   // cause flag register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         power_control_reg <= `RCR_POR_VALUE;                // RULE_02
      else
         power_control_reg <= next_power_control_reg;                     // RULE_01
   end

   // time-out and power-down status flags
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         timeout_flag   <= 1'b1;                             // RULE_02
         powerdown_flag <= 1'b1;
      end else begin
         unique case (ev)
            rcr_pkg::EV_BOR: begin                           // RULE_13
               timeout_flag   <= 1'b1;
               powerdown_flag <= 1'b1;
            end
            rcr_pkg::EV_PIN: begin
               if (sleeping) begin                           // RULE_04
                  timeout_flag   <= 1'b1;
                  powerdown_flag <= 1'b0;
               end
            end
            rcr_pkg::EV_WDT: begin
               timeout_flag <= 1'b0;                         // RULE_05 RULE_12
               if (sleeping)
                  powerdown_flag <= 1'b0;                    // RULE_05
            end
            rcr_pkg::EV_WAKE, rcr_pkg::EV_SLEEP: begin       // RULE_06
               timeout_flag   <= 1'b1;
               powerdown_flag <= 1'b0;
            end
            rcr_pkg::EV_CLRWDT: begin
               timeout_flag   <= 1'b1;
               powerdown_flag <= 1'b1;
            end
            default: ;                                       // flags unchanged
         endcase
      end
   end

   // run state: sleep, wake, and wait for one instruction before vectoring
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         st <= rcr_pkg::ST_RUN;
      else if (true_rst)
         st <= rcr_pkg::ST_RUN;
      else if (ev == rcr_pkg::EV_SLEEP)
         st <= rcr_pkg::ST_SLEEP;
      else if (ev == rcr_pkg::EV_WDT)
         st <= rcr_pkg::ST_RUN;                              // RULE_05
      else if (ev == rcr_pkg::EV_WAKE)
         st <= global_int_enable ? rcr_pkg::ST_VEC_WAIT      // RULE_07
                                 : rcr_pkg::ST_RUN;
      else if (st == rcr_pkg::ST_VEC_WAIT && instr_retired)
         st <= rcr_pkg::ST_RUN;
   end

   // program counter requests and return push
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         core_restart <= 1'b0;
         pc_load      <= 1'b0;
         pc_load_addr <= PC_W'(`RCR_RESET_VEC);
         stack_push   <= 1'b0;
         push_addr    <= PC_W'(`RCR_RESET_VEC);
      end else begin
         core_restart <= true_rst;
         stack_push   <= 1'b0;
         pc_load      <= 1'b0;
         if (true_rst) begin
            pc_load      <= 1'b1;                            // RULE_01
            pc_load_addr <= PC_W'(`RCR_RESET_VEC);
         end else if (ev == rcr_pkg::EV_WAKE || ev == rcr_pkg::EV_WDT) begin
            pc_load      <= 1'b1;                            // RULE_05 RULE_06
            pc_load_addr <= pc_next(core_pc);
         end else if (st == rcr_pkg::ST_VEC_WAIT && instr_retired) begin
            pc_load      <= 1'b1;                            // RULE_07
            pc_load_addr <= PC_W'(`RCR_INT_VEC);
            stack_push   <= 1'b1;
            push_addr    <= pc_next(core_pc);
         end
      end
   end

   // helper: no event or write seen since power-on
   logic untouched;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         untouched <= 1'b1;
      else if (ev != rcr_pkg::EV_NONE || power_control_reg_wr)
         untouched <= 1'b0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_reset_pc_zero: assert property (                        // RULE_01
      true_rst |=> core_restart && pc_load && pc_load_addr == PC_W'(`RCR_RESET_VEC))
      else $error("reset did not load pc zero");
   a_por_defaults: assert property (                         // RULE_02
      untouched |-> power_control_reg == `RCR_POR_VALUE && timeout_flag && powerdown_flag)
      else $error("power-on flags wrong");
   a_pin_run_only: assert property (                         // RULE_03
      ev == rcr_pkg::EV_PIN && !sleeping && !power_control_reg_wr |=>
         power_control_reg == ($past(power_control_reg) & ~(8'h01 << `RCR_PIN_BIT))
         && $stable(timeout_flag) && $stable(powerdown_flag))
      else $error("pin reset touched other flags");
   a_pin_sleep: assert property (                            // RULE_04
      ev == rcr_pkg::EV_PIN && sleeping |=>
         !power_control_reg[`RCR_PIN_BIT] && timeout_flag && !powerdown_flag)
      else $error("pin reset in sleep flags wrong");
   a_wdt_wake: assert property (                             // RULE_05
      ev == rcr_pkg::EV_WDT && sleeping && !power_control_reg_wr |=> !timeout_flag
         && !powerdown_flag && !core_restart && $stable(power_control_reg)
         && pc_load && pc_load_addr == pc_next($past(core_pc)))
      else $error("watchdog wake wrong");
   a_int_wake: assert property (                             // RULE_06
      ev == rcr_pkg::EV_WAKE |=> timeout_flag && !powerdown_flag && !asleep
         && pc_load && !core_restart)
      else $error("interrupt wake wrong");
   a_vec_wait_entry: assert property (                       // RULE_07
      ev == rcr_pkg::EV_WAKE && global_int_enable |=> !stack_push
         && st == rcr_pkg::ST_VEC_WAIT)
      else $error("enabled wake did not wait for one instruction");
   // a wake cannot fall in the wait state and a watchdog there is a true reset
   a_vec_after_one: assert property (                        // RULE_07
      st == rcr_pkg::ST_VEC_WAIT && instr_retired && !true_rst |=>
         stack_push && pc_load && pc_load_addr == PC_W'(`RCR_INT_VEC)
         && push_addr == pc_next($past(core_pc)))
      else $error("vector not taken after one instruction");
   a_ovf_flag: assert property (                             // RULE_08
      ev == rcr_pkg::EV_OVF |=> power_control_reg[`RCR_OVF_BIT] && core_restart)
      else $error("overflow reset wrong");
   a_unf_flag: assert property (                             // RULE_09
      ev == rcr_pkg::EV_UNF |=> power_control_reg[`RCR_UNF_BIT] && core_restart)
      else $error("underflow reset wrong");
   a_gap_zero: assert property (                             // RULE_10
      !power_control_reg[`RCR_GAP_BIT])
      else $error("unimplemented bit set");
   a_wdt_reset: assert property (                            // RULE_12
      ev == rcr_pkg::EV_WDT && !sleeping |=>
         !power_control_reg[`RCR_WDT_BIT] && !timeout_flag && core_restart)
      else $error("watchdog reset wrong");
   a_bor_flags: assert property (                            // RULE_13
      ev == rcr_pkg::EV_BOR |=> power_control_reg[`RCR_OVF_BIT:`RCR_UNF_BIT] == 2'b00
         && !power_control_reg[`RCR_BOR_BIT] && timeout_flag && powerdown_flag)
      else $error("brown-out flags wrong");

   c_pin_reset:  cover property (ev == rcr_pkg::EV_PIN ##1 core_restart);
   c_wdt_wake:   cover property (ev == rcr_pkg::EV_WDT && sleeping);
   c_vector:     cover property (stack_push);
   c_sw_rewrite: cover property (power_control_reg_wr && ev == rcr_pkg::EV_NONE);

endmodule : rcr_top

// file: dv/reset_cause_recorder_test.sv
// self-checking bench for the reset cause recorder top
// assumes rtl/rcr_params.svh and rtl/rcr_top.sv are compiled first
`timescale 1ns/10ps
module reset_cause_recorder_test;
   localparam int PW = 15;                   // pc width under test
   // expected outputs for one answer cycle
   typedef struct {
      logic [7:0]    pcr;                    // cause flags
      logic          to, pd, slp;            // status flags and sleep
      logic          rst, ld, psh;           // one-cycle pulses
      logic [PW-1:0] addr, paddr;            // load and push address
   } rcr_note_t;
   logic          clk;                       // core clock
   logic          nrst;                      // reset, active low
   logic          pin_n;                     // reset pin, active low
   logic [9:0]    ev;                        // one strobe per event kind
   logic          stack_fault_reset_enable;  // stack reset on
   logic          global_int_enable;         // interrupts enabled
   logic [PW-1:0] core_pc;                   // pc seen by the block
   logic [7:0]    wdata;                     // software write data
   logic          chk;                       // marks the answer cycle
   logic [7:0]    power_control_reg;         // cause flags out
   logic          timeout_flag;              // time-out out
   logic          powerdown_flag;            // power-down out
   logic          asleep;                    // sleep state out
   logic          core_restart;              // restart pulse
   logic          pc_load;                   // pc load pulse
   logic [PW-1:0] pc_load_addr;              // pc to load
   logic          stack_push;                // push pulse
   logic [PW-1:0] push_addr;                 // pushed address
   rcr_note_t     e;                         // expected state
   rcr_note_t     q[$];                      // notes awaiting results
   rcr_note_t     n;                         // note being compared
   logic [PW-1:0] pc;                        // pc chosen for a wake
   logic [7:0]    r;                         // random write value
   int            n_fail;                    // mismatches
   int            compares;                  // comparisons made

   rcr_top #(.PC_W(PW)) DUT (
      .clk(clk), .nrst(nrst), .ext_reset_pin_n(pin_n),
      .bor_event(ev[0]), .wdt_expire(ev[1]), .reset_instr(ev[2]),
      .stack_ovf(ev[3]), .stack_unf(ev[4]), .int_wake(ev[5]),
      .sleep_enter(ev[6]), .clrwdt_instr(ev[7]), .instr_retired(ev[8]),
      .stack_fault_reset_enable(stack_fault_reset_enable),
      .global_int_enable(global_int_enable), .core_pc(core_pc),
      .power_control_reg_wr(ev[9]), .power_control_reg_wdata(wdata),
      .power_control_reg(power_control_reg), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .asleep(asleep),
      .core_restart(core_restart), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .stack_push(stack_push),
      .push_addr(push_addr)
   );

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // print counts and verdict, then stop
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // compare the oldest note once its answer cycle has settled
   always @(negedge clk) begin
      if (chk) begin
         n = q.pop_front();
         compares++;
         if (power_control_reg !== n.pcr || timeout_flag !== n.to ||
             powerdown_flag !== n.pd || asleep !== n.slp ||
             core_restart !== n.rst || pc_load !== n.ld || stack_push !== n.psh ||
             (n.ld && pc_load_addr !== n.addr) || (n.psh && push_addr !== n.paddr)) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %h %b%b%b %b%b%b %h %h want %h %b%b%b %b%b%b %h %h",
                     $time, power_control_reg, timeout_flag, powerdown_flag, asleep,
                     core_restart, pc_load, stack_push, pc_load_addr, push_addr,
                     n.pcr, n.to, n.pd, n.slp, n.rst, n.ld, n.psh, n.addr, n.paddr);
         end
      end
   end

   // drop the pulse expectations once a result is noted
   task automatic clr;
      e.rst = 1'b0;
      e.ld  = 1'b0;
      e.psh = 1'b0;
   endtask : clr

   // pulse one strobe; the answer is due one edge after it is taken
   task automatic go(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      q.push_back(e);
      @(posedge clk);
      ev[b] <= 1'b0;
      chk   <= 1'b1;
      @(posedge clk);
      chk   <= 1'b0;
      clr();
   endtask : go

   // pin low: synchroniser and edge detect put the answer three edges out
   task automatic pin_rst;
      @(posedge clk);
      pin_n <= 1'b0;
      q.push_back(e);
      repeat (2) @(posedge clk);
      @(posedge clk);
      chk <= 1'b1;
      @(posedge clk);
      chk   <= 1'b0;
      pin_n <= 1'b1;
      repeat (3) @(posedge clk);
      clr();
   endtask : pin_rst

   // hold reset ten cycles, then expect the power-on state
   task automatic por;
      nrst <= 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      e = '{pcr: 8'h1c, to: 1'b1, pd: 1'b1, default: '0};
      @(posedge clk);
      q.push_back(e);
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
   endtask : por

   // expect a true reset to address zero
   task automatic boot;
      e.rst  = 1'b1;
      e.ld   = 1'b1;
      e.addr = '0;
   endtask : boot

   // enter sleep: time-out high, power-down low
   task automatic nap;
      e.to  = 1'b1;
      e.pd  = 1'b0;
      e.slp = 1'b1;
      go(6);
   endtask : nap

   // pick a random pc and expect a wake to resume after it
   task automatic wake_at(input logic to);
      pc = PW'($urandom);
      core_pc <= pc;
      e.to   = to;
      e.pd   = 1'b0;
      e.slp  = 1'b0;
      e.ld   = 1'b1;
      e.addr = pc + 1'b1;
   endtask : wake_at

   // software rewrite of every flag to one
   task automatic ones;
      wdata <= 8'hff;
      e.pcr = 8'hdf;
      go(9);
   endtask : ones

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   // main sequence
   initial begin
      nrst = 1'b0; pin_n = 1'b1; ev = '0; chk = 1'b0; wdata = '0; core_pc = '0;
      stack_fault_reset_enable = 1'b0; global_int_enable = 1'b0;
      n_fail = 0; compares = 0;
      void'($urandom(32'h753ff47e));
      por();
      done("power-on");
      repeat (4) begin
         r = 8'($urandom);
         wdata <= r;
         e.pcr = r & 8'hdf;
         go(9);
      end
      ones();
      done("write");
      e.pcr[4] = 1'b0; e.to = 1'b0; boot(); go(1);
      e.pcr[2] = 1'b0; boot(); go(2);
      wdata <= 8'h0b; e.pcr = 8'h0b; go(9);
      go(3); go(4);
      stack_fault_reset_enable <= 1'b1;
      e.pcr[7] = 1'b1; boot(); go(3);
      e.pcr[6] = 1'b1; boot(); go(4);
      ones();
      e.pcr = 8'h1e; e.to = 1'b1; e.pd = 1'b1; boot(); go(0);
      e.pcr[3] = 1'b0; boot(); pin_rst();
      done("resets");
      nap(); go(2);
      wake_at(1'b0); go(1);
      nap(); wake_at(1'b1); go(5);
      go(5);
      ones(); nap();
      e.pcr[3] = 1'b0; e.to = 1'b1; e.slp = 1'b0; boot(); pin_rst();
      done("sleep");
      global_int_enable <= 1'b1;
      nap(); wake_at(1'b1); go(5);
      pc = PW'($urandom);
      core_pc <= pc;
      e.psh = 1'b1; e.paddr = pc + 1'b1; e.ld = 1'b1; e.addr = PW'(4); go(8);
      e.to = 1'b1; e.pd = 1'b1; go(7);
      done("vector");
      por();
      done("second reset");
      close_out();
   end

   // cut a hang short
   initial begin
      #20000;
      n_fail++;
      close_out();
   end
endmodule : reset_cause_recorder_test
